// ### shared/aci_pkg.sv
/*
 aci_pkg: constants, types and helpers of the amplifier control slave.
 assumes: compiled before the interface and both design modules.
*/
// Behaviour
// R1 - serves bus clocks up to 100 kHz standard and 400 kHz fast.
// R2 - slave only: no arbitration, no clock stretching, no wait states.
// R3 - bytes of eight bits, most significant bit first, one per clock.
// R4 - receiver of each byte returns acknowledge in the following clock.
// R5 - start is falling data with clock high; stop is rising data.
// R6 - data changes only while clock is low, except start and stop.
// R7 - device acknowledges by holding data low through the whole clock.
// R8 - device answers slave address 0011 011, byte 0x36 with direction bit.
// R9 - any number of bytes between start and stop, no length limit.
// R10 - byte registers single or multi byte; coefficients in whole words only.
// R11 - reads return successive bytes from the subaddress while master acknowledges.
// R12 - unimplemented bits of a read subaddress return zero.
// R13 - biquad write needs five full words, else its data is dropped.
// R14 - mixer coefficient write commits only after one full word.
// R15 - sequential writes advance subaddress; data sent decides how many.
// R16 - only the incomplete final subaddress set is dropped.
// R17 - write: direction 0, device acks subaddress and data, master stops.
// R18 - address byte acknowledged only after own address and direction bit.
// R19 - read: subaddress write, repeated start, direction 1, then data.
// R20 - master ends a read with not-acknowledge then stop.
// R21 - control port works with the audio master clock absent.
// R22 - large writes may be split into transactions of four-byte multiples.
// R23 - foreign address: no ack, data released, idle until next start.
package aci_pkg;
   // address byte with direction bit clear; the 7-bit address is its top bits
   localparam logic [7:0] ADDR_BYTE_WR = 8'h36;
   localparam int WORD_BYTES = 4;
   localparam int BIQ_WORDS = 5;
   localparam int MIX_WORDS = 1;
   localparam logic [4:0] REG_BYTES = 5'h01;
   localparam logic [4:0] MIX_BYTES = 5'(MIX_WORDS * WORD_BYTES);
   localparam logic [4:0] BIQ_BYTES = 5'(BIQ_WORDS * WORD_BYTES);
   // subaddress map of coefficient regions
   localparam logic [7:0] SUB_BIQ_FIRST = 8'h29;
   localparam logic [7:0] SUB_BIQ_LAST = 8'h3f;
   localparam logic [7:0] SUB_MIX_FIRST = 8'h40;
   localparam logic [7:0] SUB_MIX_LAST = 8'h4f;
   localparam int COEF_BITS = 26;
   // timing: fastest bus clock period against the link sampling clock
   localparam int T_SCL_FAST_NS = 2500;
   localparam int T_SCL_STD_NS = 10000;
   localparam int T_LINK_NS = 125;
   localparam int SCL_FAST_CYC = T_SCL_FAST_NS / T_LINK_NS;
   localparam int MIN_OVERSAMPLE = 16;
   // one subaddress worth of data, word 0 first
   typedef logic [4:0][31:0] aci_set_t;
   typedef enum logic [2:0] {
      LK_IDLE = 3'b000,
      LK_RX = 3'b001,
      LK_ACK = 3'b010,
      LK_TX = 3'b011,
      LK_RACK = 3'b100
   } aci_lk_st_t;
   typedef enum logic [1:0] {
      KD_ADDR = 2'b00,
      KD_SUB = 2'b01,
      KD_DATA = 2'b10
   } aci_kind_t;

   // bytes that make up one complete set at a subaddress
   function automatic logic [4:0] aci_set_bytes(input logic [7:0] sub);
      if (sub >= SUB_BIQ_FIRST && sub <= SUB_BIQ_LAST)
         return BIQ_BYTES;
      else if (sub >= SUB_MIX_FIRST && sub <= SUB_MIX_LAST)
         return MIX_BYTES;
      return REG_BYTES;
   endfunction

   // place a received byte, words big-endian
   function automatic aci_set_t aci_put(input aci_set_t s, input logic [4:0] idx,
                                        input logic [4:0] nb, input logic [7:0] b);
      aci_set_t r;
      r = s;
      if (nb == REG_BYTES) begin
         r = '0;
         r[0][7:0] = b;
      end else begin
         r[idx[4:2]][{~idx[1:0], 3'b000} +: 8] = b;
      end
      return r;
   endfunction

   // byte to send for position idx of a set
   function automatic logic [7:0] aci_pick(input aci_set_t s, input logic [4:0] idx,
                                           input logic [4:0] nb);
      if (nb == REG_BYTES)
         return s[0][7:0];
      return s[idx[4:2]][{~idx[1:0], 3'b000} +: 8];
   endfunction

   // clear bits a subaddress does not hold
   function automatic aci_set_t aci_mask(input aci_set_t s, input logic [4:0] nb, input int bits);
      aci_set_t r;
      logic [31:0] m;
      m = 32'hffffffff >> (32 - bits);
      for (int i = 0; i < BIQ_WORDS; i++) begin
         if (nb == REG_BYTES)
            r[i] = (i == 0) ? (s[i] & 32'h000000ff) : 32'h00000000;
         else if (5'(i * WORD_BYTES) < nb)
            r[i] = s[i] & m;
         else
            r[i] = 32'h00000000;
      end
      return r;
   endfunction
endpackage

// ### shared/aci_xfer_if.sv
/*
 aci_xfer_if: words passing between the link domain and the system domain.
 assumes: toggles mark events; data stands still while its toggle settles.
*/
`timescale 1ns/1ps
interface aci_xfer_if;
   import aci_pkg::*;
   logic wr_tog;
   logic [7:0] wr_addr;
   logic [4:0] wr_bytes;
   aci_set_t wr_data;
   logic rd_tog;
   logic [7:0] rd_addr;
   logic [4:0] rd_bytes;
   logic rd_ack_tog;
   aci_set_t rd_data;
   modport link (output wr_tog, wr_addr, wr_bytes, wr_data, rd_tog, rd_addr, rd_bytes,
                 input rd_ack_tog, rd_data);
   modport core (input wr_tog, wr_addr, wr_bytes, wr_data, rd_tog, rd_addr, rd_bytes,
                 output rd_ack_tog, rd_data);
endinterface

// ### design/aci_core_port.sv
/*
 aci_core_port: system-clock side of the crossing to the register core.
 assumes: link side holds data stable for several system cycles per toggle.
*/
`timescale 1ns/1ps
module aci_core_port #(
   parameter int COEF_BITS = aci_pkg::COEF_BITS
) (
   // system clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // link side
   aci_xfer_if.core x,
   // register write side
   output logic o_wr_stb,
   output logic [7:0] o_wr_addr,
   output logic [4:0] o_wr_bytes,
   output aci_pkg::aci_set_t o_wr_data,
   // register read side
   output logic o_rd_req,
   output logic [7:0] o_rd_addr,
   output logic [4:0] o_rd_bytes,
   input wire logic i_rd_valid,
   input wire aci_pkg::aci_set_t i_rd_data
);
   import aci_pkg::*;

   if (COEF_BITS < 1 || COEF_BITS > 32) begin
      $error("coefficient width must be 1 to 32");
   end

   typedef struct packed {
      logic wr_s1;
      logic wr_s2;
      logic wr_s3;
      logic rd_s1;
      logic rd_s2;
      logic rd_s3;
      logic wr_stb;
      logic [7:0] wr_addr;
      logic [4:0] wr_bytes;
      aci_set_t wr_data;
      logic rd_req;
      logic rd_wait;
      logic [7:0] rd_addr;
      logic [4:0] rd_bytes;
      logic rd_ack_tog;
      aci_set_t rd_data;
   } aci_cp_st_t;

   aci_cp_st_t cur_ff;
   aci_cp_st_t nxt_cur;

   // toggle synchronisers; only stage two and three feed the edge detect
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.wr_s1 = x.wr_tog;
      nxt_cur.wr_s2 = cur_ff.wr_s1;
      nxt_cur.wr_s3 = cur_ff.wr_s2;
      nxt_cur.rd_s1 = x.rd_tog;
      nxt_cur.rd_s2 = cur_ff.rd_s1;
      nxt_cur.rd_s3 = cur_ff.rd_s2;
      nxt_cur.wr_stb = cur_ff.wr_s2 ^ cur_ff.wr_s3;
      nxt_cur.rd_req = 1'b0;
      if (cur_ff.wr_s2 ^ cur_ff.wr_s3) begin
         nxt_cur.wr_addr = x.wr_addr;
         nxt_cur.wr_bytes = x.wr_bytes;
         nxt_cur.wr_data = x.wr_data;
      end
      if (cur_ff.rd_s2 ^ cur_ff.rd_s3) begin
         nxt_cur.rd_req = 1'b1;
         nxt_cur.rd_wait = 1'b1;
         nxt_cur.rd_addr = x.rd_addr;
         nxt_cur.rd_bytes = x.rd_bytes;
      end else if (cur_ff.rd_wait && i_rd_valid) begin
         nxt_cur.rd_wait = 1'b0;
         nxt_cur.rd_data = aci_mask(i_rd_data, cur_ff.rd_bytes, COEF_BITS); // [R12]
         nxt_cur.rd_ack_tog = ~cur_ff.rd_ack_tog;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         cur_ff <= '0;
      else
         cur_ff <= nxt_cur;
   end

   assign o_wr_stb = cur_ff.wr_stb;
   assign o_wr_addr = cur_ff.wr_addr;
   assign o_wr_bytes = cur_ff.wr_bytes;
   assign o_wr_data = cur_ff.wr_data;
   assign o_rd_req = cur_ff.rd_req;
   assign o_rd_addr = cur_ff.rd_addr;
   assign o_rd_bytes = cur_ff.rd_bytes;
   assign x.rd_ack_tog = cur_ff.rd_ack_tog;
   assign x.rd_data = cur_ff.rd_data;
endmodule

// ### design/aci_ctrl_slave.sv
/*
 aci_ctrl_slave: two-wire control slave of the amplifier, top level.
 the bus engine runs on its own sampling clock and hands whole register
 sets to the system domain through aci_core_port.
 assumes: I_LINK_CLK runs free at least 16 times the fastest bus clock;
 the register core answers each read request within a few system cycles;
 SDA is open drain with an external pull-up.
*/
`timescale 1ns/1ps
module aci_ctrl_slave #(
   parameter logic [7:0] ADDR_BYTE = aci_pkg::ADDR_BYTE_WR,
   parameter int COEF_BITS = aci_pkg::COEF_BITS,
   parameter int LINK_NS = aci_pkg::T_LINK_NS
) (
   // system clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // link sampling clock
   input wire logic I_LINK_CLK,
   // bus pins; data pin is open drain
   input wire logic I_SCL,
   input wire logic I_SDA,
   output logic O_SDA_O,
   output logic O_SDA_OE,
   // register write side
   output logic O_WR_STB,
   output logic [7:0] O_WR_ADDR,
   output logic [4:0] O_WR_BYTES,
   output aci_pkg::aci_set_t O_WR_DATA,
   // register read side
   output logic O_RD_REQ,
   output logic [7:0] O_RD_ADDR,
   output logic [4:0] O_RD_BYTES,
   input wire logic I_RD_VALID,
   input wire aci_pkg::aci_set_t I_RD_DATA
);
   import aci_pkg::*;

   // the engine needs enough samples per bus bit at fast-mode rate
   localparam int OVERSAMPLE = T_SCL_FAST_NS / LINK_NS;

   if (OVERSAMPLE < MIN_OVERSAMPLE) begin // [R1]
      $error("link clock too slow for fast-mode bus clock");
   end
   if (ADDR_BYTE[0] != 1'b0) begin
      $error("address byte must have its direction bit clear");
   end

   // whole link-domain state
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic rak_s1;
      logic rak_s2;
      logic rak_d;
      aci_lk_st_t st;
      aci_kind_t kind;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw_rd;
      logic [7:0] sub;
      logic [4:0] nb;
      logic [4:0] idx;
      aci_set_t wbuf;
      logic wr_tog;
      logic [7:0] wr_addr;
      logic [4:0] wr_bytes;
      aci_set_t wr_data;
      logic rd_tog;
      logic rd_pend;
      logic [7:0] rd_addr;
      logic [4:0] rd_bytes;
      logic sda_oe;
      logic sda_o;
   } aci_lk_t;

   aci_lk_t lk_ff;
   aci_lk_t nxt_lk;
   logic lrst_s1_ff;
   logic lrst_s2_ff;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic rd_done;
   logic load;
   logic [4:0] nb_new;
   aci_set_t put_set;

   aci_xfer_if x();

   // system reset carried into the link domain; the link clock runs free
   always_ff @(posedge I_LINK_CLK) begin
      lrst_s1_ff <= I_SYS_RST;
      lrst_s2_ff <= lrst_s1_ff;
   end

   // edges seen on the synchronised pins only; start and stop need clock high
   assign scl_rise = lk_ff.scl_s2 & ~lk_ff.scl_d;
   assign scl_fall = ~lk_ff.scl_s2 & lk_ff.scl_d;
   assign bus_start = lk_ff.scl_s2 & lk_ff.scl_d & lk_ff.sda_d & ~lk_ff.sda_s2; // [R5]
   assign bus_stop = lk_ff.scl_s2 & lk_ff.scl_d & ~lk_ff.sda_d & lk_ff.sda_s2; // [R5]
   assign rd_done = lk_ff.rak_s2 ^ lk_ff.rak_d;
   assign nb_new = aci_set_bytes(lk_ff.sh);
   assign put_set = aci_put(lk_ff.wbuf, lk_ff.idx, lk_ff.nb, lk_ff.sh);

   // bus engine: everything happens on sampled edges, so no wait states
   // are ever needed and the clock line is never touched
   always_comb begin
      nxt_lk = lk_ff;
      load = 1'b0;
      nxt_lk.scl_s1 = I_SCL;
      nxt_lk.scl_s2 = lk_ff.scl_s1;
      nxt_lk.scl_d = lk_ff.scl_s2;
      nxt_lk.sda_s1 = I_SDA;
      nxt_lk.sda_s2 = lk_ff.sda_s1;
      nxt_lk.sda_d = lk_ff.sda_s2;
      nxt_lk.rak_s1 = x.rd_ack_tog;
      nxt_lk.rak_s2 = lk_ff.rak_s1;
      nxt_lk.rak_d = lk_ff.rak_s2;
      nxt_lk.sda_o = 1'b0;
      // read data has arrived; a new request below wins over this clear
      if (rd_done)
         nxt_lk.rd_pend = 1'b0;
      if (bus_stop) begin
         // a partial set is simply forgotten: nothing left the domain yet
         nxt_lk.st = LK_IDLE;
         nxt_lk.sda_oe = 1'b0;
         nxt_lk.idx = 5'h00; // [R13] [R16]
         nxt_lk.rw_rd = 1'b0;
      end else if (bus_start) begin
         // repeated start also drops the partial set
         nxt_lk.st = LK_RX;
         nxt_lk.kind = KD_ADDR;
         nxt_lk.cnt = 4'h0;
         nxt_lk.sda_oe = 1'b0;
         nxt_lk.idx = 5'h00; // [R13] [R16]
         nxt_lk.rw_rd = 1'b0;
      end else begin
         case (lk_ff.st)
            LK_IDLE: begin
               // not addressed: line released, wait for next start
               nxt_lk.sda_oe = 1'b0; // [R23]
            end
            LK_RX: begin
               if (scl_rise && lk_ff.cnt != 4'h8) begin
                  // sample on the rising clock, msb first
                  nxt_lk.sh = {lk_ff.sh[6:0], lk_ff.sda_s2}; // [R3] [R6]
                  nxt_lk.cnt = lk_ff.cnt + 4'h1;
               end else if (scl_fall && lk_ff.cnt == 4'h8) begin
                  nxt_lk.cnt = 4'h0;
                  nxt_lk.st = LK_ACK;
                  nxt_lk.sda_oe = 1'b1; // [R4] [R17]
                  case (lk_ff.kind)
                     KD_ADDR: begin
                        if (lk_ff.sh[7:1] != ADDR_BYTE[7:1]) begin
                           // foreign address: stay off the line
                           nxt_lk.st = LK_IDLE; // [R23]
                           nxt_lk.sda_oe = 1'b0;
                        end else if (lk_ff.sh[0]) begin
                           // read: fetch the current subaddress at once [R18] [R19]
                           nxt_lk.rw_rd = 1'b1;
                           nxt_lk.idx = 5'h00;
                           nxt_lk.rd_tog = ~lk_ff.rd_tog;
                           nxt_lk.rd_pend = 1'b1;
                           nxt_lk.rd_addr = lk_ff.sub;
                           nxt_lk.rd_bytes = lk_ff.nb;
                        end else begin
                           nxt_lk.kind = KD_SUB; // [R8] [R18]
                        end
                     end
                     KD_SUB: begin
                        // subaddress opens a new set
                        nxt_lk.sub = lk_ff.sh;
                        nxt_lk.nb = nb_new; // [R10]
                        nxt_lk.idx = 5'h00;
                        nxt_lk.kind = KD_DATA;
                     end
                     KD_DATA: begin
                        nxt_lk.wbuf = put_set;
                        if (lk_ff.idx == lk_ff.nb - 5'h01) begin
                           // set complete: commit and step to next subaddress
                           nxt_lk.wr_tog = ~lk_ff.wr_tog; // [R13] [R14] [R22]
                           nxt_lk.wr_addr = lk_ff.sub;
                           nxt_lk.wr_bytes = lk_ff.nb;
                           nxt_lk.wr_data = put_set;
                           nxt_lk.sub = lk_ff.sub + 8'h01; // [R15] [R9]
                           nxt_lk.nb = aci_set_bytes(lk_ff.sub + 8'h01);
                           nxt_lk.idx = 5'h00;
                        end else begin
                           nxt_lk.idx = lk_ff.idx + 5'h01;
                        end
                     end
                     default: begin
                        nxt_lk.st = LK_IDLE;
                        nxt_lk.sda_oe = 1'b0;
                     end
                  endcase
               end
            end
            LK_ACK: begin
               // ack held low from one falling clock to the next
               if (scl_fall) begin // [R7]
                  nxt_lk.sda_oe = 1'b0;
                  nxt_lk.st = LK_RX;
                  if (lk_ff.rw_rd)
                     load = 1'b1;
               end
            end
            LK_TX: begin
               // next bit goes out just after the falling clock
               if (scl_fall) begin
                  if (lk_ff.cnt == 4'h7) begin
                     nxt_lk.sda_oe = 1'b0;
                     nxt_lk.st = LK_RACK;
                     nxt_lk.cnt = 4'h0;
                  end else begin
                     nxt_lk.sh = {lk_ff.sh[6:0], 1'b1}; // [R3] [R6]
                     nxt_lk.sda_oe = ~lk_ff.sh[6];
                     nxt_lk.cnt = lk_ff.cnt + 4'h1;
                  end
               end
            end
            LK_RACK: begin
               // master ack keeps the read going; not-ack ends it
               if (scl_rise) begin
                  if (lk_ff.sda_s2)
                     nxt_lk.st = LK_IDLE; // [R20]
                  else
                     nxt_lk.cnt = 4'h8; // [R11]
               end else if (scl_fall && lk_ff.cnt == 4'h8) begin
                  load = 1'b1;
               end
            end
            default: begin
               nxt_lk.st = LK_IDLE;
               nxt_lk.sda_oe = 1'b0;
            end
         endcase
      end
      // load one read byte; a late fetch shows as a released line
      if (load) begin
         nxt_lk.st = LK_TX;
         nxt_lk.cnt = 4'h0;
         nxt_lk.sh = lk_ff.rd_pend ? 8'hff : aci_pick(x.rd_data, lk_ff.idx, lk_ff.rd_bytes); // [R12]
         nxt_lk.sda_oe = ~nxt_lk.sh[7];
         if (lk_ff.idx == lk_ff.rd_bytes - 5'h01) begin
            // last byte of this set: prefetch the next subaddress
            nxt_lk.idx = 5'h00; // [R11]
            nxt_lk.sub = lk_ff.rd_addr + 8'h01;
            nxt_lk.nb = aci_set_bytes(lk_ff.rd_addr + 8'h01);
            nxt_lk.rd_addr = lk_ff.rd_addr + 8'h01;
            nxt_lk.rd_bytes = aci_set_bytes(lk_ff.rd_addr + 8'h01);
            nxt_lk.rd_tog = ~lk_ff.rd_tog;
            nxt_lk.rd_pend = 1'b1;
         end else begin
            nxt_lk.idx = lk_ff.idx + 5'h01;
         end
      end
   end

   // pins idle high in reset so no false start is seen on release
   always_ff @(posedge I_LINK_CLK) begin
      if (lrst_s2_ff) begin
         lk_ff <= '0;
         lk_ff.scl_s1 <= 1'b1;
         lk_ff.scl_s2 <= 1'b1;
         lk_ff.scl_d <= 1'b1;
         lk_ff.sda_s1 <= 1'b1;
         lk_ff.sda_s2 <= 1'b1;
         lk_ff.sda_d <= 1'b1;
         lk_ff.st <= LK_IDLE;
         lk_ff.nb <= REG_BYTES;
         lk_ff.rd_bytes <= REG_BYTES;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // link-side words held stable until the next toggle
   assign x.wr_tog = lk_ff.wr_tog;
   assign x.wr_addr = lk_ff.wr_addr;
   assign x.wr_bytes = lk_ff.wr_bytes;
   assign x.wr_data = lk_ff.wr_data;
   assign x.rd_tog = lk_ff.rd_tog;
   assign x.rd_addr = lk_ff.rd_addr;
   assign x.rd_bytes = lk_ff.rd_bytes;

   // data pin only ever pulled low; clock pin has no driver at all [R2]
   assign O_SDA_O = lk_ff.sda_o;
   assign O_SDA_OE = lk_ff.sda_oe;

   // system side; needs only I_CLK, never the audio master clock [R21]
   aci_core_port #(
      .COEF_BITS(COEF_BITS)
   ) u_core_port (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .x(x.core),
      .o_wr_stb(O_WR_STB),
      .o_wr_addr(O_WR_ADDR),
      .o_wr_bytes(O_WR_BYTES),
      .o_wr_data(O_WR_DATA),
      .o_rd_req(O_RD_REQ),
      .o_rd_addr(O_RD_ADDR),
      .o_rd_bytes(O_RD_BYTES),
      .i_rd_valid(I_RD_VALID),
      .i_rd_data(I_RD_DATA)
   );
endmodule

// ### sim/aci_ctrl_slave_assertions.sv
/*
 checker: bus pin and core port relations of the control slave.
 assumes: bound to aci_ctrl_slave; data wire resolved outside with a pull-up.
*/
`timescale 1ns/1ps
module aci_ctrl_slave_assertions import aci_pkg::*; (
   // clocks and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_LINK_CLK,
   // bus side
   input wire logic I_SCL,
   input wire logic O_SDA_O,
   input wire logic O_SDA_OE,
   // core side
   input wire logic O_WR_STB,
   input wire logic [7:0] O_WR_ADDR,
   input wire logic [4:0] O_WR_BYTES,
   input wire logic O_RD_REQ,
   input wire logic [7:0] O_RD_ADDR,
   input wire logic [4:0] O_RD_BYTES
);
   // a strobe is high for exactly one system cycle
   sequence s_one_pulse(sig);
      sig ##1 !sig;
   endsequence
   a_stb_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      O_WR_STB |-> s_one_pulse(O_WR_STB)) else $error("write strobe wider than one cycle");
   a_req_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      O_RD_REQ |-> s_one_pulse(O_RD_REQ)) else $error("read request wider than one cycle");
   a_biq_set_size: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      O_WR_STB && O_WR_ADDR >= 8'h29 && O_WR_ADDR <= 8'h3f |-> O_WR_BYTES == 5'h14)
      else $error("biquad set not twenty bytes");
   a_mix_set_size: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      O_WR_STB && O_WR_ADDR[7:4] == 4'h4 |-> O_WR_BYTES == 5'h04) else $error("mixer set not four bytes");
   a_rd_set_size: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      O_RD_REQ && O_RD_ADDR[7:4] == 4'h4 |-> O_RD_BYTES == 5'h04) else $error("mixer read not four bytes");
   a_wr_addr_held: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      !O_WR_STB |-> $stable(O_WR_ADDR)) else $error("write address moved without strobe");
   a_rd_addr_held: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      !O_RD_REQ |-> $stable(O_RD_ADDR)) else $error("read address moved without request");
   // pin side: open drain, changes only while the bus clock is low
   a_sda_drive_low: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
      O_SDA_OE |-> !O_SDA_O) else $error("data pin driven high");
   a_oe_scl_low: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
      $changed(O_SDA_OE) |-> !I_SCL) else $error("data moved while clock high");
   a_ack_held: assert property (@(posedge I_LINK_CLK) disable iff (I_SYS_RST)
      O_SDA_OE && I_SCL |=> O_SDA_OE) else $error("data released during clock high");
endmodule
bind aci_ctrl_slave aci_ctrl_slave_assertions aci_ctrl_slave_assertions_i (.I_CLK(I_CLK),
   .I_SYS_RST(I_SYS_RST), .I_LINK_CLK(I_LINK_CLK), .I_SCL(I_SCL), .O_SDA_O(O_SDA_O),
   .O_SDA_OE(O_SDA_OE), .O_WR_STB(O_WR_STB), .O_WR_ADDR(O_WR_ADDR), .O_WR_BYTES(O_WR_BYTES),
   .O_RD_REQ(O_RD_REQ), .O_RD_ADDR(O_RD_ADDR), .O_RD_BYTES(O_RD_BYTES));

// ### sim/aci_bus_master.sv
/*
 aci_bus_master: bus controller model, bit-banging clock and data at 400 kHz.
 assumes: the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module aci_bus_master #(
   parameter int Q = 625
) (
   // bus pins; clock stands high between frames
   output logic o_scl,
   output logic o_sda_m,
   input wire logic i_sda
);
   // idle bus, both lines released
   initial begin
      o_scl = 1'b1;
      o_sda_m = 1'b1;
   end
   // start or repeated start: data falls while clock high
   task automatic start();
      #Q o_sda_m = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_m = 1'b0;
      #Q o_scl = 1'b0;
   endtask
   // stop: data rises while clock high
   task automatic stop();
      #Q o_sda_m = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_m = 1'b1;
      #Q;
   endtask
   // one bit; data moves mid-low, sampled mid-high
   task automatic xbit(input logic b, output logic r);
      #Q o_sda_m = b;
      #Q o_scl = 1'b1;
      #Q r = i_sda;
      #Q o_scl = 1'b0;
   endtask
   // a byte msb first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] tx, input logic am, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         xbit(tx[i], rx[i]);
      end
      xbit(am, ack);
   endtask
endmodule

// ### sim/aci_ctrl_slave_tb_top.sv
/*
 testbench: bus writes, refused address, partial sets and reads of the slave.
 assumes: core answers reads one cycle after each request with a fixed pattern.
*/
`timescale 1ns/1ps
module aci_ctrl_slave_tb_top;
   import aci_pkg::*;
   logic clk, rst, lclk, scl, sda_m, oe, stb, req, rd_valid, a;
   logic [7:0] wr_addr, r, rd_addr;
   logic [4:0] wr_bytes, rd_bytes;
   logic [12:0] rq;
   logic sda_o;
   aci_set_t wr_data;
   wire logic sda;
   int bad_count, checks, cyc;
   logic [44:0] wq[$];
   // pull-up: wire low only where someone pulls
   assign sda = sda_m & ~oe;
   aci_ctrl_slave aci_ctrl_slave_i (.I_CLK(clk), .I_SYS_RST(rst), .I_LINK_CLK(lclk), .I_SCL(scl),
      .I_SDA(sda), .O_SDA_O(sda_o), .O_SDA_OE(oe), .O_WR_STB(stb), .O_WR_ADDR(wr_addr),
      .O_WR_BYTES(wr_bytes), .O_WR_DATA(wr_data), .O_RD_REQ(req), .O_RD_ADDR(rd_addr),
      .O_RD_BYTES(rd_bytes),
      .I_RD_VALID(rd_valid), .I_RD_DATA({5{32'hfedcba98}}));
   aci_bus_master aci_bus_master_i (.o_scl(scl), .o_sda_m(sda_m), .i_sda(sda));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // link clock, phase offset on purpose
   initial begin
      lclk = 1'b0;
      #17;
      forever #62.5 lclk = ~lclk;
   end
   // core answer, strobe capture and hang guard
   always @(posedge clk) begin
      rd_valid <= #1 req;
      if (stb === 1'b1) wq.push_back({wr_addr, wr_bytes, wr_data[0]});
      if (req === 1'b1) rq <= {rd_addr, rd_bytes};
      cyc <= cyc + 1;
      // whole run is about 96k cycles; the ceiling stays under 100k
      if (cyc == 99000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // write one byte and judge the acknowledge slot
   task automatic wb(input logic [7:0] b, input logic e);
      aci_bus_master_i.xbyte(b, 1'b1, r, a);
      chk(64'(a), 64'(e));
   endtask
   task automatic settle();
      aci_bus_master_i.stop();
      repeat (100) @(posedge clk);
   endtask
   task automatic t_reg_write();
      wq.delete();
      aci_bus_master_i.start();
      wb(8'h36, 1'b0);
      wb(8'h05, 1'b0);
      wb(8'hab, 1'b0);
      wb(8'hcd, 1'b0);
      settle();
      chk(64'(wq.size()), 64'd2);
      chk(64'(wq[0]), 64'({8'h05, 5'h01, 32'h000000ab}));
      chk(64'(wq[1]), 64'({8'h06, 5'h01, 32'h000000cd}));
   endtask
   task automatic t_foreign();
      wq.delete();
      aci_bus_master_i.start();
      wb(8'ha0, 1'b1);
      settle();
      chk(64'(wq.size()), 64'd0);
   endtask
   // partial biquad cut by restart, full mixer word, partial tail
   task automatic t_set_write();
      wq.delete();
      aci_bus_master_i.start();
      wb(8'h36, 1'b0);
      wb(8'h29, 1'b0);
      wb(8'hd1, 1'b0);
      aci_bus_master_i.start();
      wb(8'h36, 1'b0);
      wb(8'h40, 1'b0);
      for (int i = 1; i <= 5; i++) begin
         wb(8'(8'h11 * i), 1'b0);
      end
      settle();
      chk(64'(wq.size()), 64'd1);
      chk(64'(wq[0]), 64'({8'h40, 5'h04, 32'h11223344}));
   endtask
   task automatic t_read();
      aci_bus_master_i.start();
      wb(8'h36, 1'b0);
      wb(8'h40, 1'b0);
      aci_bus_master_i.start();
      wb(8'h37, 1'b0);
      aci_bus_master_i.xbyte(8'hff, 1'b0, r, a);
      chk(64'(r), 64'h02);
      aci_bus_master_i.xbyte(8'hff, 1'b1, r, a);
      chk(64'(r), 64'hdc);
      settle();
      chk(64'(rq), 64'({8'h40, 5'h04}));
      chk(64'(sda_o), 64'h0);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // reset long enough for the link side synchroniser
   initial begin
      rst = 1'b1;
      repeat (120) @(posedge clk);
      #1 rst = 1'b0;
      repeat (400) @(posedge clk);
      t_reg_write();
      t_foreign();
      t_set_write();
      t_read();
      tally_and_finish();
   end
endmodule
